/* logic/spa_pkg.sv */
`default_nettype none
package spa_pkg;
  // ******************************************************************
  // register indices and bus addresses
  // ******************************************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] IDX_PWR_CTRL = 12'h087;
  localparam logic [ADDR_W-1:0] IDX_SER_CTRL = 12'h098;
  localparam logic [ADDR_W-1:0] IDX_SER_BUF = 12'h099;
  localparam logic [ADDR_W-1:0] IDX_IRQ_EN = 12'h0a8;
  localparam logic [ADDR_W-1:0] IDX_NODE_ADDR0 = 12'h0a9;
  localparam logic [ADDR_W-1:0] IDX_NODE_ADDR1 = 12'h0aa;
  localparam logic [ADDR_W-1:0] IDX_IRQ_PRIO = 12'h0b8;
  localparam logic [ADDR_W-1:0] IDX_ADDR_MASK0 = 12'h0b9;
  localparam logic [ADDR_W-1:0] IDX_ADDR_MASK1 = 12'h0ba;
  localparam int ADDR_SHIFT = 2;
  // ******************************************************************
  // field positions
  // ******************************************************************
  localparam int PWR_BAUD_DOUBLE = 7;
  localparam int PWR_FE_SELECT = 6;
  localparam int CTL_MODE_A = 7;
  localparam int CTL_MODE_B = 6;
  localparam int CTL_MULTI = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TI = 1;
  localparam int CTL_RI = 0;
  localparam int IE_GLOBAL = 7;
  localparam int IE_SER0 = 4;
  localparam int IP_SER0 = 4;
  localparam int IP_UNUSED = 7;
  // ******************************************************************
  // reset values
  // ******************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [10:0] RST_TX_SH = 11'h7ff;
  // ******************************************************************
  // timing counts
  // ******************************************************************
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [2:0] M2_DIV_SLOW = 3'h4;
  localparam logic [2:0] M2_DIV_FAST = 3'h2;
  localparam logic [3:0] M0_PER_SLOW = 4'hc;
  localparam logic [3:0] M0_PER_FAST = 4'h4;
  localparam logic [2:0] M0_LAST_BIT = 3'h7;
  localparam logic [3:0] IDX_STOP10 = 4'h9;
  localparam logic [3:0] IDX_STOP11 = 4'ha;
  localparam logic [3:0] IDX_LAST_DATA = 4'h8;
  // ******************************************************************
  // modes and states
  // ******************************************************************
  typedef enum logic [1:0] {
    MODE_SYNC = 2'h0, MODE_A10 = 2'h1, MODE_A11_FIX = 2'h2, MODE_A11_VAR = 2'h3
  } spa_mode_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h1, TX_ASYNC = 3'h2, TX_SYNC = 3'h4
  } spa_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1, RX_ASYNC = 3'h2, RX_SYNC = 3'h4
  } spa_rx_st_t;
endpackage
`default_nettype wire

/* logic/spa_serial_port.sv */
// Notes on behaviour
// R1: two mode bits select sync or async modes
// R2: invalid stop sets frame error, software clears
// R3: select bit maps top bit to frame error
// R4: baud double halves bit time modes 1-3
// R5: modes 2/3 multiprocessor: ninth zero, no flag
// R6: mode 1 multiprocessor: bad stop, no flag
// R7: mode 0 shift clock divides by 12 or 4
// R8: receive only while receive enable set
// R9: modes 2/3 send software ninth bit
// R10: ninth bit or stop bit stored on receive
// R11: transmit flag at bit 8 or stop start
// R12: receive flag at bit 8 or mid stop
// R13: data address: read receive, write transmit
// R14: software loads node address register
// R15: compare address bits only where mask set
// R16: all-zero mask accepts any address
// R17: second address and mask registers are stored but never used in the compare
// R18: receive and transmit on port 3 bits 0/1
// R19: interrupt gated by own and global enable
// R20: priority bit selects high level
// R21: variable rate from external timer overflow
// R22: only ninth-bit-one frames are address-compared
`timescale 1ns/1ps
`default_nettype none
module spa_serial_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spa_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bit rate source
  input wire logic timer_ovf,
  // port 3 bit 0 receive pin
  input wire logic p3_rxd_in,
  output logic p3_rxd_out,
  output logic p3_rxd_oe_n,
  // port 3 bit 1 transmit pin
  output logic p3_txd_out,
  // interrupt request to core
  output logic serial0_irq_req,
  output logic serial0_irq_high
);
  import spa_pkg::*;
  // ******************************************************************
  // registers
  // ******************************************************************
  logic baud_double_q, frame_error_select_q;
  logic mode_bit_a_q, mode_bit_b_q, multiprocessor_bit_q, ren_q;
  logic transmit_ninth_bit_q, receive_ninth_bit_q, transmit_flag_q, receive_flag_q;
  logic frame_error_q;
  logic [7:0] rx_buf_q, irq_en_q, irq_prio_q;
  logic [7:0] node_addr0_q, node_addr1_q, addr_mask0_q, addr_mask1_q;
  logic [31:0] prdata_q;
  spa_tx_st_t tx_st_q, tx_st_d;
  spa_rx_st_t rx_st_q, rx_st_d;
  logic [10:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_os_q, tx_os_d, tx_idx_q, tx_idx_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_ninth_q, rx_ninth_d;
  logic [3:0] rx_os_q, rx_os_d, rx_idx_q, rx_idx_d;
  logic rxd_prev_q, ovf_half_q;
  logic [2:0] m2_cnt_q, m0_bit_q;
  logic [3:0] m0_div_q;
  logic ti_set, ri_set, fe_set, rb8_set, rb8_val;
  // ******************************************************************
  // address match
  // ******************************************************************
  // comparison is applied only to the first address and mask pair (node_addr0_q, addr_mask0_q)
  function automatic logic addr_hit(input logic [7:0] data, input logic [7:0] node,
                                    input logic [7:0] mask);
    addr_hit = ((data ^ node) & mask) == 8'h00; // R15 R16 R17
  endfunction
  // ******************************************************************
  // apb decode
  // ******************************************************************
  wire sel_pwr = paddr == (IDX_PWR_CTRL << ADDR_SHIFT);
  wire sel_ctl = paddr == (IDX_SER_CTRL << ADDR_SHIFT);
  wire sel_buf = paddr == (IDX_SER_BUF << ADDR_SHIFT);
  wire sel_ie = paddr == (IDX_IRQ_EN << ADDR_SHIFT);
  wire sel_na0 = paddr == (IDX_NODE_ADDR0 << ADDR_SHIFT);
  wire sel_na1 = paddr == (IDX_NODE_ADDR1 << ADDR_SHIFT);
  wire sel_ip = paddr == (IDX_IRQ_PRIO << ADDR_SHIFT);
  wire sel_am0 = paddr == (IDX_ADDR_MASK0 << ADDR_SHIFT);
  wire sel_am1 = paddr == (IDX_ADDR_MASK1 << ADDR_SHIFT);
  wire hit = sel_pwr | sel_ctl | sel_buf | sel_ie | sel_na0 | sel_na1 | sel_ip | sel_am0
             | sel_am1;
  wire access = psel & penable;
  wire wr_ok = access & pwrite & hit;
  wire wr_pwr = wr_ok & sel_pwr;
  wire wr_ctl = wr_ok & sel_ctl;
  wire wr_buf = wr_ok & sel_buf;
  wire [7:0] wd = pwdata[7:0];
  wire top_bit = frame_error_select_q ? frame_error_q : mode_bit_a_q; // R3
  wire [7:0] ctl_rd = {top_bit, mode_bit_b_q, multiprocessor_bit_q, ren_q,
                       transmit_ninth_bit_q, receive_ninth_bit_q, transmit_flag_q,
                       receive_flag_q};
  wire [7:0] pwr_rd = {baud_double_q, frame_error_select_q, 6'h00};
  wire [7:0] ip_rd = {1'b1, irq_prio_q[IP_UNUSED-1:0]};
  wire [7:0] rd_byte = sel_pwr ? pwr_rd :
                       sel_ctl ? ctl_rd :
                       sel_buf ? rx_buf_q : // R13
                       sel_ie ? irq_en_q :
                       sel_na0 ? node_addr0_q :
                       sel_na1 ? node_addr1_q :
                       sel_ip ? ip_rd :
                       sel_am0 ? addr_mask0_q :
                       sel_am1 ? addr_mask1_q : 8'h00;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // ******************************************************************
  // mode and rate
  // ******************************************************************
  spa_mode_t mode;
  assign mode = spa_mode_t'({mode_bit_a_q, mode_bit_b_q}); // R1
  wire mode0 = mode == MODE_SYNC;
  wire mode1 = mode == MODE_A10;
  wire mode2 = mode == MODE_A11_FIX;
  wire mode_var = mode1 | (mode == MODE_A11_VAR);
  wire [2:0] m2_lim = (baud_double_q ? M2_DIV_FAST : M2_DIV_SLOW) - 3'h1; // R4
  wire os_tick_var = timer_ovf & (baud_double_q | ovf_half_q); // R21 R4
  wire os_tick_fix = mode2 & (m2_cnt_q == m2_lim);
  wire os_tick = mode_var ? os_tick_var : os_tick_fix;
  wire [3:0] m0_per = multiprocessor_bit_q ? M0_PER_FAST : M0_PER_SLOW; // R7
  wire sync_act = (tx_st_q == TX_SYNC) | (rx_st_q == RX_SYNC);
  wire m0_rise = sync_act & (m0_div_q == (m0_per >> 1));
  wire m0_end = sync_act & (m0_div_q == m0_per - 4'h1);
  wire sclk = m0_div_q >= (m0_per >> 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m2_cnt_q <= 3'h0;
      ovf_half_q <= 1'b0;
    end else begin
      m2_cnt_q <= (!mode2 || os_tick_fix) ? 3'h0 : m2_cnt_q + 3'h1;
      ovf_half_q <= timer_ovf ? ~ovf_half_q : ovf_half_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m0_div_q <= 4'h0;
      m0_bit_q <= 3'h0;
    end else if (!sync_act) begin
      m0_div_q <= 4'h0;
      m0_bit_q <= 3'h0;
    end else begin
      m0_div_q <= m0_end ? 4'h0 : m0_div_q + 4'h1;
      m0_bit_q <= m0_end ? m0_bit_q + 3'h1 : m0_bit_q;
    end
  end

  // ******************************************************************
  // transmitter
  // ******************************************************************
  wire [3:0] tx_last = mode1 ? IDX_STOP10 : IDX_STOP11;
  wire ninth_out = mode1 ? 1'b1 : transmit_ninth_bit_q; // R9

  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_os_d = tx_os_q;
    tx_idx_d = tx_idx_q;
    ti_set = 1'b0;
    case (tx_st_q)
      TX_IDLE: begin
        if (wr_buf && mode0 && rx_st_q == RX_IDLE) begin
          tx_st_d = TX_SYNC;
          tx_sh_d = {3'h7, wd};
        end else if (wr_buf && !mode0) begin
          tx_st_d = TX_ASYNC;
          tx_sh_d = {1'b1, ninth_out, wd, 1'b0};
          tx_os_d = 4'h0;
          tx_idx_d = 4'h0;
        end
      end
      TX_ASYNC: begin
        if (os_tick) begin
          tx_os_d = tx_os_q + 4'h1;
          if (tx_os_q == OS_LAST && tx_idx_q == tx_last) begin
            tx_st_d = TX_IDLE;
          end else if (tx_os_q == OS_LAST) begin
            tx_idx_d = tx_idx_q + 4'h1;
            tx_sh_d = {1'b1, tx_sh_q[10:1]};
            ti_set = (tx_idx_q + 4'h1) == tx_last; // R11
          end
        end
      end
      TX_SYNC: begin
        if (m0_end) begin
          tx_sh_d = {1'b1, tx_sh_q[10:1]};
          if (m0_bit_q == M0_LAST_BIT) begin
            tx_st_d = TX_IDLE;
            ti_set = 1'b1; // R11
          end
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= RST_TX_SH;
      tx_os_q <= 4'h0;
      tx_idx_q <= 4'h0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_os_q <= tx_os_d;
      tx_idx_q <= tx_idx_d;
    end
  end

  // ******************************************************************
  // receiver
  // ******************************************************************
  wire rx_stop_idx = (mode1 && rx_idx_q == IDX_STOP10) || rx_idx_q == IDX_STOP11;
  wire stop_ok = p3_rxd_in;
  wire is_addr_ok = rx_ninth_q & addr_hit(rx_sh_q, node_addr0_q, addr_mask0_q); // R22 R14
  wire m1_accept = ~multiprocessor_bit_q | stop_ok; // R6
  wire m23_accept = ~multiprocessor_bit_q | is_addr_ok; // R5 R22
  wire async_accept = ~receive_flag_q & (mode1 ? m1_accept : m23_accept);

  always_comb begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_ninth_d = rx_ninth_q;
    rx_os_d = rx_os_q;
    rx_idx_d = rx_idx_q;
    ri_set = 1'b0;
    fe_set = 1'b0;
    rb8_set = 1'b0;
    rb8_val = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        if (ren_q && mode0 && !receive_flag_q && tx_st_q == TX_IDLE && !wr_buf) begin
          rx_st_d = RX_SYNC; // R8
        end else if (ren_q && !mode0 && rxd_prev_q && !p3_rxd_in) begin
          rx_st_d = RX_ASYNC; // R8
          rx_os_d = 4'h0;
          rx_idx_d = 4'h0;
        end
      end
      RX_ASYNC: begin
        if (!ren_q) begin
          rx_st_d = RX_IDLE; // R8
        end else if (os_tick) begin
          rx_os_d = rx_os_q + 4'h1;
          if (rx_os_q == OS_MID) begin
            rx_idx_d = rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && p3_rxd_in) begin
              rx_st_d = RX_IDLE;
            end else if (rx_idx_q != 4'h0 && rx_idx_q <= IDX_LAST_DATA) begin
              rx_sh_d = {p3_rxd_in, rx_sh_q[7:1]};
            end else if (rx_stop_idx) begin
              rx_st_d = RX_IDLE;
              fe_set = ~stop_ok; // R2
              ri_set = async_accept; // R12
              rb8_set = async_accept; // R10
              rb8_val = mode1 ? stop_ok : rx_ninth_q; // R10
            end else if (rx_idx_q == IDX_STOP10) begin
              rx_ninth_d = p3_rxd_in;
            end
          end
        end
      end
      RX_SYNC: begin
        if (!ren_q) begin
          rx_st_d = RX_IDLE; // R8
        end else if (m0_rise) begin
          rx_sh_d = {p3_rxd_in, rx_sh_q[7:1]};
        end else if (m0_end && m0_bit_q == M0_LAST_BIT) begin
          rx_st_d = RX_IDLE;
          ri_set = 1'b1; // R12
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= RST_BYTE;
      rx_ninth_q <= 1'b0;
      rx_os_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rxd_prev_q <= 1'b1;
      rx_buf_q <= RST_BYTE;
    end else begin
      rx_st_q <= rx_st_d;
      rx_sh_q <= rx_sh_d;
      rx_ninth_q <= rx_ninth_d;
      rx_os_q <= rx_os_d;
      rx_idx_q <= rx_idx_d;
      rxd_prev_q <= p3_rxd_in;
      rx_buf_q <= ri_set ? rx_sh_q : rx_buf_q; // R13
    end
  end

  // ******************************************************************
  // control register and flags
  // ******************************************************************
  wire fe_wr = wr_ctl & frame_error_select_q;
  wire sm0_wr = wr_ctl & ~frame_error_select_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_bit_a_q <= 1'b0;
      mode_bit_b_q <= 1'b0;
      multiprocessor_bit_q <= 1'b0;
      ren_q <= 1'b0;
      transmit_ninth_bit_q <= 1'b0;
    end else if (wr_ctl) begin
      mode_bit_a_q <= sm0_wr ? wd[CTL_MODE_A] : mode_bit_a_q; // R3
      mode_bit_b_q <= wd[CTL_MODE_B];
      multiprocessor_bit_q <= wd[CTL_MULTI];
      ren_q <= wd[CTL_REN];
      transmit_ninth_bit_q <= wd[CTL_TB8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_error_q <= 1'b0;
      transmit_flag_q <= 1'b0;
      receive_flag_q <= 1'b0;
      receive_ninth_bit_q <= 1'b0;
    end else begin
      frame_error_q <= fe_set | (fe_wr ? wd[CTL_MODE_A] : frame_error_q); // R2
      transmit_flag_q <= ti_set | (wr_ctl ? wd[CTL_TI] : transmit_flag_q); // R11
      receive_flag_q <= ri_set | (wr_ctl ? wd[CTL_RI] : receive_flag_q); // R12
      receive_ninth_bit_q <= rb8_set ? rb8_val :
                             wr_ctl ? wd[CTL_RB8] : receive_ninth_bit_q; // R10
    end
  end

  // ******************************************************************
  // plain registers
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_double_q <= 1'b0;
      frame_error_select_q <= 1'b0;
      irq_en_q <= RST_BYTE;
      irq_prio_q <= RST_BYTE;
    end else begin
      baud_double_q <= wr_pwr ? wd[PWR_BAUD_DOUBLE] : baud_double_q;
      frame_error_select_q <= wr_pwr ? wd[PWR_FE_SELECT] : frame_error_select_q;
      irq_en_q <= (wr_ok & sel_ie) ? wd : irq_en_q;
      irq_prio_q <= (wr_ok & sel_ip) ? wd : irq_prio_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_addr0_q <= RST_BYTE;
      node_addr1_q <= RST_BYTE;
      addr_mask0_q <= RST_BYTE;
      addr_mask1_q <= RST_BYTE;
    end else begin
      node_addr0_q <= (wr_ok & sel_na0) ? wd : node_addr0_q; // R14
      node_addr1_q <= (wr_ok & sel_na1) ? wd : node_addr1_q; // R17
      addr_mask0_q <= (wr_ok & sel_am0) ? wd : addr_mask0_q;
      addr_mask1_q <= (wr_ok & sel_am1) ? wd : addr_mask1_q; // R17
    end
  end

  // ******************************************************************
  // pins and interrupt request
  // ******************************************************************
  assign p3_rxd_out = tx_sh_q[0]; // R18
  assign p3_rxd_oe_n = tx_st_q != TX_SYNC; // R18
  assign p3_txd_out = sync_act ? sclk : (tx_st_q == TX_ASYNC) ? tx_sh_q[0] : 1'b1; // R18
  assign serial0_irq_req = (transmit_flag_q | receive_flag_q) & irq_en_q[IE_SER0]
                           & irq_en_q[IE_GLOBAL]; // R19
  assign serial0_irq_high = irq_prio_q[IP_SER0]; // R20

endmodule // spa_serial_port
`default_nettype wire

/* sim/spa_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module spa_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spa_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupt lines
  input wire logic serial0_irq_req,
  input wire logic serial0_irq_high
);
  import spa_pkg::*;
  // ******************************************************************
  // bus and interrupt checks
  // ******************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [ADDR_W-1:0] idx;
  logic mapped;
  logic acc;
  logic wr_acc;
  assign idx = paddr >> ADDR_SHIFT;
  assign mapped = idx inside {IDX_PWR_CTRL, IDX_SER_CTRL, IDX_SER_BUF, IDX_IRQ_EN,
    IDX_NODE_ADDR0, IDX_NODE_ADDR1, IDX_IRQ_PRIO, IDX_ADDR_MASK0, IDX_ADDR_MASK1};
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  pready_const_a: assert property (pready)
    else $error("pready low");
  slverr_access_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  slverr_map_a: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  unmapped_zero_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  prdata_upper_a: assert property (prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  prdata_hold_a: assert property (!psel |=> $stable(prdata))
    else $error("prdata moved while idle");
  prio_bit7_a: assert property (psel && !penable && !pwrite && idx == IDX_IRQ_PRIO
    |=> prdata[IP_UNUSED])
    else $error("priority bit 7 not high");
  irq_global_a: assert property (wr_acc && idx == IDX_IRQ_EN && !pwdata[IE_GLOBAL]
    |=> !serial0_irq_req)
    else $error("irq without global enable");
  irq_prio_a: assert property (wr_acc && idx == IDX_IRQ_PRIO
    |=> serial0_irq_high == $past(pwdata[IP_SER0]))
    else $error("priority level wrong");
endmodule // spa_monitor
bind spa_serial_port spa_monitor u_spa_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial0_irq_req(serial0_irq_req), .serial0_irq_high(serial0_irq_high));
`default_nettype wire

/* sim/spa_remote_node.sv */
`timescale 1ns/1ps
`default_nettype none
module spa_remote_node (
  // clock
  input wire logic pclk,
  // serial lines
  input wire logic txd,
  output logic rxd
);
  // ******************************************************************
  // mode 2 peer, 64 pclk per bit, idle line high
  // ******************************************************************
  localparam int BIT_T = 64;
  logic [8:0] got_q;
  logic got_stop;
  int got_cnt;
  initial begin
    rxd = 1'b1;
    got_cnt = 0;
  end
  // send start, 8 data lsb first, ninth and stop
  task automatic send(input logic [7:0] d, input logic ninth, input logic stop);
    logic [10:0] fr;
    fr = {stop, ninth, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= fr[i];
      repeat (BIT_T) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  // capture frames from the block at mid bit
  always begin
    @(negedge txd);
    repeat (BIT_T / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_T) @(posedge pclk);
      got_q[i] = txd;
    end
    repeat (BIT_T) @(posedge pclk);
    got_stop = txd;
    got_cnt++;
  end
endmodule // spa_remote_node
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spa_pkg::*;
  // ******************************************************************
  // stimulus and checks
  // ******************************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic timer_ovf = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd_pin;
  logic node_rxd;
  logic rxd_out;
  logic rxd_oe_n;
  logic txd;
  logic irq_req;
  logic irq_high;
  int failures = 0;
  int compares = 0;
  localparam logic [7:0] M_DAT [4] = '{8'h3a, 8'h33, 8'hfa, 8'h81};
  localparam logic M_NINE [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  localparam logic [7:0] M_MASK [4] = '{8'h0f, 8'h0f, 8'h0f, 8'h00};
  localparam logic [7:0] M_CTL [4] = '{8'hb0, 8'hb0, 8'hb5, 8'hb5};
  localparam logic [7:0] M_BUF [4] = '{8'h3c, 8'h3c, 8'hfa, 8'h81};
  always #10 pclk = ~pclk;
  logic [1:0] ovf_cnt = 2'h0;
  always @(posedge pclk) begin
    ovf_cnt <= ovf_cnt + 2'h1;
    timer_ovf <= ovf_cnt == 2'h3;
  end
  assign rxd_pin = rxd_oe_n ? node_rxd : rxd_out;
  spa_serial_port u_spa_serial_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_ovf(timer_ovf), .p3_rxd_in(rxd_pin),
    .p3_rxd_out(rxd_out), .p3_rxd_oe_n(rxd_oe_n), .p3_txd_out(txd),
    .serial0_irq_req(irq_req), .serial0_irq_high(irq_high));
  spa_remote_node u_spa_remote_node (.pclk(pclk), .txd(txd), .rxd(node_rxd));
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= idx << ADDR_SHIFT;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd_chk(input string name, input logic [ADDR_W-1:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    check(name, exp, r);
  endtask
  task automatic t_regs();
    logic [7:0] r;
    logic e;
    rd_chk("ctl reset", IDX_SER_CTRL, 8'h00);
    rd_chk("prio reset", IDX_IRQ_PRIO, 8'h80);
    wr(IDX_NODE_ADDR1, 8'hc3);
    wr(IDX_ADDR_MASK1, 8'h3c);
    rd_chk("node1", IDX_NODE_ADDR1, 8'hc3);
    rd_chk("mask1", IDX_ADDR_MASK1, 8'h3c);
    apb(1'b0, 12'h0a0, 8'h00, r, e);
    check("unmapped data", 8'h00, r);
    check("unmapped err", 8'h01, {7'h0, e});
    $display("test regs done");
  endtask
  task automatic t_tx();
    int n;
    n = 0;
    wr(IDX_SER_CTRL, 8'h98);
    wr(IDX_SER_BUF, 8'ha5);
    while (u_spa_remote_node.got_cnt == 0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check("tx data", 8'ha5, u_spa_remote_node.got_q[7:0]);
    check("tx ninth", 8'h01, {7'h0, u_spa_remote_node.got_q[8]});
    check("tx stop", 8'h01, {7'h0, u_spa_remote_node.got_stop});
    rd_chk("tx flag", IDX_SER_CTRL, 8'h9a);
    wr(IDX_SER_CTRL, 8'h90);
    $display("test tx done");
  endtask
  task automatic t_rx();
    u_spa_remote_node.send(8'h3c, 1'b1, 1'b1);
    rd_chk("rx ctl", IDX_SER_CTRL, 8'h95);
    rd_chk("rx buf", IDX_SER_BUF, 8'h3c);
    wr(IDX_IRQ_EN, 8'h10);
    @(posedge pclk);
    check("irq no global", 8'h00, {7'h0, irq_req});
    wr(IDX_IRQ_EN, 8'h90);
    @(posedge pclk);
    check("irq on", 8'h01, {7'h0, irq_req});
    wr(IDX_IRQ_PRIO, 8'h10);
    @(posedge pclk);
    check("irq high", 8'h01, {7'h0, irq_high});
    rd_chk("prio", IDX_IRQ_PRIO, 8'h90);
    wr(IDX_IRQ_EN, 8'h00);
    $display("test rx done");
  endtask
  task automatic t_multi();
    wr(IDX_NODE_ADDR0, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_ADDR_MASK0, M_MASK[i]);
      wr(IDX_SER_CTRL, 8'hb0);
      u_spa_remote_node.send(M_DAT[i], M_NINE[i], 1'b1);
      rd_chk("mp ctl", IDX_SER_CTRL, M_CTL[i]);
      rd_chk("mp buf", IDX_SER_BUF, M_BUF[i]);
    end
    $display("test multi done");
  endtask
  task automatic t_frame();
    wr(IDX_PWR_CTRL, 8'h40);
    wr(IDX_SER_CTRL, 8'h10);
    u_spa_remote_node.send(8'h11, 1'b1, 1'b0);
    rd_chk("fe set", IDX_SER_CTRL, 8'h95);
    wr(IDX_SER_CTRL, 8'h10);
    rd_chk("fe clear", IDX_SER_CTRL, 8'h10);
    wr(IDX_PWR_CTRL, 8'h00);
    rd_chk("mode bit", IDX_SER_CTRL, 8'h90);
    wr(IDX_SER_CTRL, 8'h80);
    u_spa_remote_node.send(8'h77, 1'b1, 1'b1);
    rd_chk("ren off ctl", IDX_SER_CTRL, 8'h80);
    rd_chk("ren off buf", IDX_SER_BUF, 8'h11);
    $display("test frame done");
  endtask
  task automatic t_var();
    wr(IDX_PWR_CTRL, 8'h80);
    wr(IDX_SER_CTRL, 8'h70);
    u_spa_remote_node.send(8'h5c, 1'b0, 1'b1);
    rd_chk("m1 bad stop", IDX_SER_CTRL, 8'h70);
    u_spa_remote_node.send(8'ha6, 1'b1, 1'b1);
    rd_chk("m1 ctl", IDX_SER_CTRL, 8'h75);
    rd_chk("m1 buf", IDX_SER_BUF, 8'ha6);
    wr(IDX_SER_CTRL, 8'hd0);
    u_spa_remote_node.send(8'h3e, 1'b0, 1'b1);
    rd_chk("m3 ctl", IDX_SER_CTRL, 8'hd1);
    rd_chk("m3 buf", IDX_SER_BUF, 8'h3e);
    $display("test var done");
  endtask
  task automatic t_sync();
    logic [7:0] s;
    time t0;
    wr(IDX_SER_CTRL, 8'h20);
    wr(IDX_SER_BUF, 8'hc5);
    @(posedge pclk);
    check("sync oe", 8'h00, {7'h0, rxd_oe_n});
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      if (i == 0) t0 = $time;
      s[i] = rxd_out;
    end
    check("sync period", 8'h1c, 8'(($time - t0) / 20));
    check("sync data", 8'hc5, s);
    repeat (2) @(posedge pclk);
    rd_chk("sync flag", IDX_SER_CTRL, 8'h22);
    $display("test sync done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_multi();
    t_frame();
    t_var();
    t_sync();
    conclude();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    conclude();
  end
endmodule // tb
`default_nettype wire
